//--- logic/lookup_index_unknown_fwd_cfg.svh
`ifndef LOOKUP_INDEX_UNKNOWN_FWD_CFG_SVH
`define LOOKUP_INDEX_UNKNOWN_FWD_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, 16-bit register address port)
// ----------------------------------------------------------------------
`define LIUF_OFS_FULL_FAIL_INDEX  16'h0316
`define LIUF_OFS_LEARN_FAIL_INDEX 16'h0318
`define LIUF_OFS_HOST_INDEX       16'h031A
`define LIUF_OFS_UUC_CTRL         16'h0320
`define LIUF_OFS_UMC_CTRL         16'h0324
`define LIUF_OFS_UVID_CTRL        16'h0328
`define LIUF_OFS_FAIL_STATUS      16'h0314

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LIUF_ENABLE_BIT           31
`define LIUF_MASK_MSB             6
`define LIUF_STAT_WRITE_FAIL_BIT  0
`define LIUF_STAT_ALMOST_FULL_BIT 1
`define LIUF_STAT_LEARN_FAIL_BIT  2
`define LIUF_ALMOST_FULL_MIN      3'h2
`define LIUF_ALMOST_FULL_MAX      3'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LIUF_RST_INDEX            12'h000
`define LIUF_RST_CTRL             32'h00000000
`define LIUF_RST_STATUS           3'h0

`endif

//--- logic/lookup_index_unknown_fwd_pkg.sv
package lookup_index_unknown_fwd_pkg;

    typedef logic [6:0] port_mask_type;

    typedef enum logic [1:0] {
        CLASS_NONE,
        CLASS_UNKNOWN_VID,
        CLASS_UNKNOWN_UNICAST,
        CLASS_UNKNOWN_MULTICAST
    } fwd_class_type;

    typedef struct packed {
        logic [11:0]   full_fail_index;
        logic [9:0]    learn_fail_index;
        logic [9:0]    host_index;
        logic          uuc_enable;
        port_mask_type uuc_mask;
        logic          umc_enable;
        port_mask_type umc_mask;
        logic          uvid_enable;
        port_mask_type uvid_mask;
        logic [2:0]    status;
        logic [31:0]   rdata;
        logic          fwd_valid;
        logic          fwd_hit;
        port_mask_type fwd_ports;
        fwd_class_type fwd_class;
    } state_type;

endpackage : lookup_index_unknown_fwd_pkg

//--- logic/lookup_index_unknown_fwd.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "lookup_index_unknown_fwd_cfg.svh"

// Contract
// - static write into bucket holding 2-3 statics captures 12-bit entry.
// - failed static write captures 10-bit bucket index in first index reg.
// - learn failure on four-static bucket captures 10-bit bucket index.
// - every external table read or write captures its 10-bit bucket index.
// - precedence is unknown VID, then unknown unicast, then unknown multicast.
// - unknown unicast special forwarding only while enable bit 31 is set.
// - unicast mask bit 0 is port 1; set bits select ports; zero selects none.
// - unknown multicast special forwarding only while enable bit 31 is set.
// - multicast mask bit 0 is port 1; all ones every port, zeros none.
// - unknown VID special forwarding only while its enable bit 31 is set.
// - VID mask bit 0 is port 1; each set bit selects that port.
// - learn failure raises write-one-to-clear learn-fail status flag.
// - write failure raises write-one-to-clear write-fail status flag.

module lookup_index_unknown_fwd
(
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    input  wire logic        i_clk_en,
    // register port
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // lookup engine events
    input  wire logic        i_static_wr_ok,
    input  wire logic [2:0]  i_static_wr_prior_cnt,
    input  wire logic [11:0] i_static_wr_entry,
    input  wire logic        i_static_wr_fail,
    input  wire logic [9:0]  i_static_wr_bucket,
    input  wire logic        i_learn_fail,
    input  wire logic [9:0]  i_learn_bucket,
    input  wire logic        i_host_access,
    input  wire logic [9:0]  i_host_bucket,
    // forwarding classification request
    input  wire logic        i_fwd_req,
    input  wire logic        i_unknown_vid,
    input  wire logic        i_unknown_unicast,
    input  wire logic        i_unknown_multicast,
    output logic             o_fwd_valid,
    output logic             o_fwd_hit,
    output logic      [6:0]  o_fwd_ports,
    output logic      [1:0]  o_fwd_class,
    output logic      [2:0]  o_fail_status
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] ctrl_word(
        input logic                                      en,
        input lookup_index_unknown_fwd_pkg::port_mask_type mask
    );
        ctrl_word = {en, 24'h000000, mask};
    endfunction : ctrl_word

    function automatic logic addr_is(input logic [15:0] a,
                                     input logic [15:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    lookup_index_unknown_fwd_pkg::state_type s_reg;
    lookup_index_unknown_fwd_pkg::state_type s_next;

    logic almost_full;
    logic [2:0] w1c;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        almost_full = i_static_wr_ok
                   && i_static_wr_prior_cnt >= `LIUF_ALMOST_FULL_MIN
                   && i_static_wr_prior_cnt <= `LIUF_ALMOST_FULL_MAX;
        w1c = 3'h0;

        // index capture; reads never touch these
        if (almost_full)
            s_next.full_fail_index = i_static_wr_entry;
        // a failure in the same cycle wins: it is the more urgent report
        if (i_static_wr_fail)
            s_next.full_fail_index = {2'h0, i_static_wr_bucket};
        if (i_learn_fail)
            s_next.learn_fail_index = i_learn_bucket;
        if (i_host_access)
            s_next.host_index = i_host_bucket;

        // register writes
        if (i_reg_wr)
        begin
            unique case (1'b1)
                addr_is(i_reg_addr, `LIUF_OFS_UUC_CTRL):
                begin
                    s_next.uuc_enable = i_reg_wdata[`LIUF_ENABLE_BIT];
                    s_next.uuc_mask   = i_reg_wdata[`LIUF_MASK_MSB:0];
                end
                addr_is(i_reg_addr, `LIUF_OFS_UMC_CTRL):
                begin
                    s_next.umc_enable = i_reg_wdata[`LIUF_ENABLE_BIT];
                    s_next.umc_mask   = i_reg_wdata[`LIUF_MASK_MSB:0];
                end
                addr_is(i_reg_addr, `LIUF_OFS_UVID_CTRL):
                begin
                    s_next.uvid_enable = i_reg_wdata[`LIUF_ENABLE_BIT];
                    s_next.uvid_mask   = i_reg_wdata[`LIUF_MASK_MSB:0];
                end
                addr_is(i_reg_addr, `LIUF_OFS_FAIL_STATUS):
                    w1c = i_reg_wdata[2:0];
                default:
                    w1c = 3'h0;
            endcase
        end

        // status flags: set wins over a same-cycle clear
        s_next.status = s_reg.status & ~w1c;
        if (i_static_wr_fail)
            s_next.status[`LIUF_STAT_WRITE_FAIL_BIT] = 1'b1;
        if (almost_full)
            s_next.status[`LIUF_STAT_ALMOST_FULL_BIT] = 1'b1;
        if (i_learn_fail)
            s_next.status[`LIUF_STAT_LEARN_FAIL_BIT] = 1'b1;

        // read data, one cycle after the strobe; unmapped reads zero
        s_next.rdata = 32'h00000000;
        if (i_reg_rd)
        begin
            unique case (1'b1)
                addr_is(i_reg_addr, `LIUF_OFS_FULL_FAIL_INDEX):
                    s_next.rdata = {20'h00000, s_reg.full_fail_index};
                addr_is(i_reg_addr, `LIUF_OFS_LEARN_FAIL_INDEX):
                    s_next.rdata = {22'h000000, s_reg.learn_fail_index};
                addr_is(i_reg_addr, `LIUF_OFS_HOST_INDEX):
                    s_next.rdata = {22'h000000, s_reg.host_index};
                addr_is(i_reg_addr, `LIUF_OFS_UUC_CTRL):
                    s_next.rdata = ctrl_word(s_reg.uuc_enable, s_reg.uuc_mask);
                addr_is(i_reg_addr, `LIUF_OFS_UMC_CTRL):
                    s_next.rdata = ctrl_word(s_reg.umc_enable, s_reg.umc_mask);
                addr_is(i_reg_addr, `LIUF_OFS_UVID_CTRL):
                    s_next.rdata = ctrl_word(s_reg.uvid_enable,
                                             s_reg.uvid_mask);
                addr_is(i_reg_addr, `LIUF_OFS_FAIL_STATUS):
                    s_next.rdata = {29'h00000000, s_reg.status};
                default:
                    s_next.rdata = 32'h00000000;
            endcase
        end

        // --------------------------------------------------------------
        // unknown classification; result one cycle after the request.
        // the highest-precedence category alone decides, so a disabled
        // VID category does not fall through to unicast handling.
        // --------------------------------------------------------------
        s_next.fwd_valid = i_fwd_req;
        s_next.fwd_hit   = 1'b0;
        s_next.fwd_ports = 7'h00;
        s_next.fwd_class = lookup_index_unknown_fwd_pkg::CLASS_NONE;
        if (i_fwd_req)
        begin
            if (i_unknown_vid)
            begin
                s_next.fwd_class =
                    lookup_index_unknown_fwd_pkg::CLASS_UNKNOWN_VID;
                s_next.fwd_hit   = s_reg.uvid_enable;
                s_next.fwd_ports = s_reg.uvid_enable
                                 ? s_reg.uvid_mask : 7'h00;
            end
            else if (i_unknown_unicast)
            begin
                s_next.fwd_class =
                    lookup_index_unknown_fwd_pkg::CLASS_UNKNOWN_UNICAST;
                s_next.fwd_hit   = s_reg.uuc_enable;
                s_next.fwd_ports = s_reg.uuc_enable
                                 ? s_reg.uuc_mask : 7'h00;
            end
            else if (i_unknown_multicast)
            begin
                s_next.fwd_class =
                    lookup_index_unknown_fwd_pkg::CLASS_UNKNOWN_MULTICAST;
                s_next.fwd_hit   = s_reg.umc_enable;
                s_next.fwd_ports = s_reg.umc_enable
                                 ? s_reg.umc_mask : 7'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or posedge I_RST)
    begin
        if (I_RST)
        begin
            s_reg <= '0;
            s_reg.full_fail_index <= `LIUF_RST_INDEX;
            s_reg.status <= `LIUF_RST_STATUS;
        end
        else if (i_clk_en)
        begin
            s_reg <= s_next;
        end
    end

    assign o_reg_rdata   = s_reg.rdata;
    assign o_fwd_valid   = s_reg.fwd_valid;
    assign o_fwd_hit     = s_reg.fwd_hit;
    assign o_fwd_ports   = s_reg.fwd_ports;
    assign o_fwd_class   = s_reg.fwd_class;
    assign o_fail_status = s_reg.status;

endmodule : lookup_index_unknown_fwd

//--- verification/lookup_index_unknown_fwd_monitor.sv
`timescale 1ns/100ps
// ----------------------
// capture and forwarding
// ----------------------
module lookup_index_unknown_fwd_monitor
(
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST,
    input wire logic        i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        i_static_wr_fail,
    input wire logic        i_learn_fail,
    input wire logic        i_fwd_req,
    input wire logic        i_unknown_vid,
    input wire logic        i_unknown_unicast,
    input wire logic        o_fwd_valid,
    input wire logic        o_fwd_hit,
    input wire logic [6:0]  o_fwd_ports,
    input wire logic [1:0]  o_fwd_class,
    input wire logic [2:0]  o_fail_status
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // clock enable is assumed high; a frozen design would trip these
    sequence s_req;
        i_fwd_req;
    endsequence
    sequence s_vid;
        s_req ##0 i_unknown_vid;
    endsequence
    sequence s_uc;
        s_req ##0 (!i_unknown_vid && i_unknown_unicast);
    endsequence
    a_answer_next: assert property (s_req |=> o_fwd_valid)
        else $error("no answer");
    a_no_spurious: assert property (!i_fwd_req |=> !o_fwd_valid)
        else $error("spurious answer");
    a_vid_first: assert property (s_vid |=> o_fwd_class == 2'h1)
        else $error("vid not first");
    a_unicast_next: assert property (s_uc |=> o_fwd_class == 2'h2)
        else $error("unicast not second");
    a_miss_silent: assert property (!o_fwd_hit |-> !o_fwd_ports)
        else $error("ports without hit");
    a_rdata_idle: assert property (!i_reg_rd |=> !o_reg_rdata)
        else $error("stray read data");
    a_learn_flag: assert property (i_learn_fail |=> o_fail_status[2])
        else $error("learn flag missing");
    a_fail_flag: assert property (i_static_wr_fail |=> o_fail_status[0])
        else $error("fail flag missing");
endmodule : lookup_index_unknown_fwd_monitor

//--- verification/lookup_engine_model.sv
`timescale 1ns/100ps
// ------------
// lookup side
// ------------
module lookup_engine_model
(
    input  wire logic        i_clk,
    output logic      [3:0]  o_event,
    output logic      [2:0]  o_prior_cnt,
    output logic      [11:0] o_entry,
    output logic      [9:0]  o_bucket,
    output logic             o_fwd_req,
    output logic      [2:0]  o_flags
);
    initial
    begin
        o_event = 4'h0;
        o_prior_cnt = 3'h0;
        o_entry = 12'h000;
        o_bucket = 10'h000;
        o_fwd_req = 1'b0;
        o_flags = 3'h0;
    end
    task automatic drive(input logic [3:0] ev, input logic [2:0] cnt,
        input logic [11:0] val, input logic [2:0] f, input logic req);
        @(posedge i_clk);
        o_event <= ev;
        o_prior_cnt <= cnt;
        o_entry <= val;
        o_bucket <= val[9:0];
        o_flags <= f;
        o_fwd_req <= req;
        @(posedge i_clk);
        o_event <= 4'h0;
        o_fwd_req <= 1'b0;
        // released lines turn over so a capture without strobe shows
        o_entry <= ~val;
        o_bucket <= ~val[9:0];
        o_flags <= ~f;
    endtask : drive
endmodule : lookup_engine_model

//--- verification/lookup_index_unknown_fwd_bench.sv
`timescale 1ns/100ps
// ----------
// bench top
// ----------
module lookup_index_unknown_fwd_bench;
    logic clk, rst, wr, rd, req, valid, hit;
    logic [15:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] ev;
    logic [2:0] cnt, flags, status;
    logic [11:0] entry;
    logic [9:0] bucket;
    logic [6:0] ports;
    logic [1:0] cls;
    logic [31:0] cfg [1:3];
    logic [15:0] caddr [1:3] = '{16'h0328, 16'h0320, 16'h0324};
    logic [15:0] offs [8] = '{16'h0314, 16'h0316, 16'h0318, 16'h031A,
                              16'h0320, 16'h0324, 16'h0328, 16'h0330};
    int bad_count, checks;
    lookup_index_unknown_fwd i_lookup_index_unknown_fwd
    (
        .I_CLK_SYS(clk), .I_RST(rst), .i_clk_en(1'b1), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_static_wr_ok(ev[0]), .i_static_wr_prior_cnt(cnt),
        .i_static_wr_entry(entry), .i_static_wr_fail(ev[1]),
        .i_static_wr_bucket(bucket), .i_learn_fail(ev[2]),
        .i_learn_bucket(bucket), .i_host_access(ev[3]), .i_host_bucket(bucket),
        .i_fwd_req(req), .i_unknown_vid(flags[2]),
        .i_unknown_unicast(flags[1]), .i_unknown_multicast(flags[0]),
        .o_fwd_valid(valid), .o_fwd_hit(hit), .o_fwd_ports(ports),
        .o_fwd_class(cls), .o_fail_status(status)
    );
    lookup_engine_model i_lookup_engine_model
    (
        .i_clk(clk), .o_event(ev), .o_prior_cnt(cnt), .o_entry(entry),
        .o_bucket(bucket), .o_fwd_req(req), .o_flags(flags)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : write
    task automatic read(input logic [15:0] a, input logic [31:0] want);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, want);
    endtask : read
    task automatic evt(input logic [3:0] e, input logic [2:0] n,
        input logic [11:0] v);
        i_lookup_engine_model.drive(e, n, v, 3'h0, 1'b0);
    endtask : evt
    // reserved bits are written as ones and must read back as zero
    task automatic setup();
        for (int c = 1; c <= 3; c++)
        begin
            write(caddr[c], cfg[c] | 32'h7FFFFF80);
            read(caddr[c], cfg[c]);
        end
    endtask : setup
    // highest category alone decides; a disabled one gives no fallback
    task automatic sweep();
        logic [1:0] c;
        logic [31:0] s;
        for (int f = 0; f < 8; f++)
        begin
            c = f[2] ? 2'h1 : f[1] ? 2'h2 : f[0] ? 2'h3 : 2'h0;
            s = (c == 2'h0) ? 32'h0 : cfg[c];
            i_lookup_engine_model.drive(4'h0, 3'h0, 12'h000, f[2:0], 1'b1);
            #1 chk({valid, hit, ports, cls}, {1'b1, s[31],
                s[31] ? s[6:0] : 7'h00, c});
        end
    endtask : sweep
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #(3000 * 100);
        bad_count++;
        summarize();
    end
    initial
    begin
        {rst, wr, rd, addr, wdata, bad_count, checks} = '1;
        {wr, rd, addr, wdata, bad_count, checks} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) read(offs[i], 32'h0);
        cfg = '{32'h8000007F, 32'h80000001, 32'h80000040};
        setup();
        sweep();
        cfg = '{32'h0000007F, 32'h0000007F, 32'h80000000};
        setup();
        sweep();
        write(16'h0316, 32'hFFFFFFFF);
        evt(4'h1, 3'h1, 12'h123);
        read(16'h0316, 32'h0);
        evt(4'h1, 3'h2, 12'hABC);
        read(16'h0316, 32'h00000ABC);
        evt(4'h1, 3'h3, 12'h456);
        read(16'h0316, 32'h00000456);
        evt(4'h2, 3'h0, 12'h3FF);
        read(16'h0316, 32'h000003FF);
        evt(4'h4, 3'h0, 12'h2A5);
        read(16'h0318, 32'h000002A5);
        evt(4'h8, 3'h0, 12'h155);
        read(16'h031A, 32'h00000155);
        read(16'h0318, 32'h000002A5);
        read(16'h0314, 32'h00000007);
        write(16'h0314, 32'h00000005);
        read(16'h0314, 32'h00000002);
        summarize();
    end
endmodule : lookup_index_unknown_fwd_bench
bind lookup_index_unknown_fwd lookup_index_unknown_fwd_monitor
    i_lookup_index_unknown_fwd_monitor
(
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_static_wr_fail(i_static_wr_fail),
    .i_learn_fail(i_learn_fail), .i_fwd_req(i_fwd_req),
    .i_unknown_vid(i_unknown_vid), .i_unknown_unicast(i_unknown_unicast),
    .o_fwd_valid(o_fwd_valid), .o_fwd_hit(o_fwd_hit),
    .o_fwd_ports(o_fwd_ports), .o_fwd_class(o_fwd_class),
    .o_fail_status(o_fail_status)
);
